// ===== design/dbea_data_bank.sv
// Data space paging, program memory window and EEPROM access control.
// Assumes a single-cycle core data port and external RAM, program and cell arrays.
//
// Contract
// [RL1] Window bits 5-0 give program address upper bits
// [RL2] Window register undefined, unreadable; write fully first
// [RL3] Bank value 10h maps second RAM page
// [RL4] Bank 01 and 02 map EEPROM pages
// [RL5] Addresses 00h-3Fh route to selected page
// [RL6] Bank register kept; not cleared at init
// [RL7] Bank register at E8h, write only
// [RL8] Software sets one page bit only
// [RL9] Standby or no page powers EEPROM down
// [RL10] Write starts cycle only with write enable
// [RL11] Busy high in cycle; accesses, control writes ignored
// [RL12] Idle EEPROM reads like ordinary data
// [RL13] Byte mode and eight-byte row mode
// [RL14] Row shares A7-A3; A2-A0 pick byte
// [RL15] Row mode clears latches, latches row data
// [RL16] Start programs only bytes written in row
// [RL17] Row mode and start clear after cycle
// [RL18] Start needs write enable and row mode
// [RL19] Clearing row mode abandons row unprogrammed
// [RL20] Software avoids reads, page changes in row
// [RL21] Stop instruction disables EEPROM immediately; code keeps power until a running programming cycle ends
// [RL22] Control resets 00h; bits 4,5 stay zero
// [RL23] Window occupies 40h-7Fh of data space
// [RL24] Program address is window plus 6 bits
// [RL25] Programming lasts a fixed cycle count
`timescale 1ns/10ps
`default_nettype none
`include "dbea_defines.svh"
module dbea_data_bank #(
    parameter int PROG_CYCLES = `DBEA_PROG_CYC  // Programming cycle length in clocks
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,       // Core data address
    input wire logic i_wr,               // Core write strobe
    input wire logic i_rd,               // Core read strobe
    input wire logic [7:0] i_wdata,      // Core write data
    input wire logic i_stop,             // Stop instruction executed
    input wire logic [7:0] i_ram2_rdata, // Second RAM page read data
    input wire logic [7:0] i_nvm_rdata,  // EEPROM array read data
    input wire logic [7:0] i_rom_rdata,  // Program memory read data
    output logic [7:0] o_rdata,          // Read data to core
    output logic o_rvalid,               // Read data belongs to this block
    output logic [11:0] o_rom_addr,      // Program memory address
    output logic [5:0] o_ram2_addr,      // Second RAM page address
    output logic o_ram2_we,              // Second RAM page write
    output logic [7:0] o_ram2_wdata,     // Second RAM page write data
    output logic [6:0] o_nvm_addr,       // EEPROM cell address
    output logic [7:0] o_nvm_wdata,      // EEPROM cell data
    output logic o_nvm_prog,             // EEPROM byte program pulse
    output logic o_nvm_power,            // EEPROM powered
    output logic o_nvm_busy              // Programming in progress
);
    import dbea_pkg::*;

    // Byte position within a row
    function automatic logic [2:0] dbea_col(input logic [7:0] a);
        dbea_col = a[2:0];
    endfunction

    logic [5:0] win_q;          // Window upper address bits
    logic [7:0] bank_q;         // Page select
    logic ena_q;                // Write enable
    logic off_q;                // Standby
    logic row_q;                // Row mode
    logic start_q;              // Row start
    logic stop_q;               // Stopped since stop instruction
    logic [7:0] lat_q [0:7];    // Row data latches
    logic [7:0] used_q;         // Row bytes written
    logic [2:0] row_q_addr_q;   // Latched row A5-A3
    logic row_pg_q;             // Latched row page
    logic row_set_q;            // Row address latched
    dbea_state_t st_q;          // Sequencer state
    logic [15:0] cnt_q;         // Cycle down counter
    logic [2:0] scan_q;         // Row byte being programmed
    logic [6:0] pa_q;           // Byte mode address
    logic [7:0] pd_q;           // Byte mode data
    dbea_target_t tgt;          // Access target
    logic busy;                 // Busy now
    logic nvm_on;               // EEPROM usable
    logic nvm_pg;               // Selected EEPROM page
    logic ctl_wr;               // Accepted control write
    logic row_go;               // Accepted row start write
    logic rd_q;                 // Read taken on the last edge
    logic rd_ctl_q;             // That read addressed the control register
    logic rd_nvm_ok_q;          // Cells were readable at that read
    dbea_target_t rd_tgt_q;     // Target of that read

    assign busy = (st_q != DBEA_IDLE);
    assign nvm_pg = bank_q[1];
    // Usable only with a page chosen, not standby, not stopped
    assign nvm_on = !off_q && !stop_q && (bank_q[0] || bank_q[1]); // [RL9] [RL21]
    assign ctl_wr = i_wr && (i_addr == `DBEA_ADDR_NVM_CTL) && !busy; // [RL11]
    // Start needs enable and row mode now, row mode set earlier, and a latched row
    assign row_go = ctl_wr && i_wdata[`DBEA_CTL_START] && i_wdata[`DBEA_CTL_ENA]
                    && i_wdata[`DBEA_CTL_ROW] && row_q && row_set_q; // [RL18]

    // Decode the access target
    always_comb begin
        if (i_addr <= `DBEA_PAGE_LAST) begin
            // Paged region follows the bank value
            if (bank_q[4]) begin
                tgt = DBEA_T_RAM2; // [RL3] [RL5]
            end else if (bank_q[0] || bank_q[1]) begin
                tgt = DBEA_T_NVM; // [RL4] [RL5]
            end else begin
                tgt = DBEA_T_NONE;
            end
        end else if (i_addr >= `DBEA_WIN_FIRST && i_addr <= `DBEA_WIN_LAST) begin
            tgt = DBEA_T_WIN; // [RL23]
        end else begin
            tgt = DBEA_T_CORE;
        end
    end

    // Window register, no reset, write only
    always_ff @(posedge i_clk) begin
        if (i_wr && i_addr == `DBEA_ADDR_WIN_SEL) begin
            win_q <= i_wdata[5:0]; // [RL1] [RL2]
        end
    end

    // Bank register, kept through reset
    always_ff @(posedge i_clk) begin
        if (i_wr && i_addr == `DBEA_ADDR_BANK_SEL) begin
            bank_q <= i_wdata; // [RL6] [RL7]
        end
    end

    // Control bits and stop latch
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ena_q <= 1'b0; // [RL22]
            off_q <= 1'b0;
            row_q <= 1'b0;
            start_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            if (i_stop) begin
                stop_q <= 1'b1; // [RL21]
            end else if (i_rd || i_wr) begin
                stop_q <= 1'b0;
            end
            if (st_q == DBEA_ROWP && cnt_q == 16'h0000) begin
                row_q <= 1'b0; // [RL17]
                start_q <= 1'b0;
            end else if (ctl_wr) begin
                ena_q <= i_wdata[`DBEA_CTL_ENA];
                off_q <= i_wdata[`DBEA_CTL_OFF];
                row_q <= i_wdata[`DBEA_CTL_ROW]; // [RL19]
                // Start only with enable and row mode both set
                start_q <= row_go; // [RL18]
            end
        end
    end

    // Row latches
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            used_q <= 8'h00;
            row_set_q <= 1'b0;
            row_q_addr_q <= 3'h0;
            row_pg_q <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                lat_q[i] <= 8'h00;
            end
        end else if (ctl_wr && i_wdata[`DBEA_CTL_ROW] && !row_q) begin
            used_q <= 8'h00; // [RL15]
            row_set_q <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                lat_q[i] <= 8'h00;
            end
        end else if (row_q && !busy && i_wr && tgt == DBEA_T_NVM && nvm_on) begin
            // Latch only the first row touched
            if (!row_set_q || (row_q_addr_q == i_addr[5:3] && row_pg_q == nvm_pg)) begin
                lat_q[dbea_col(i_addr)] <= i_wdata; // [RL14] [RL15]
                used_q[dbea_col(i_addr)] <= 1'b1;
                row_q_addr_q <= i_addr[5:3];
                row_pg_q <= nvm_pg;
                row_set_q <= 1'b1;
            end
        end
    end

    // Programming sequencer
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= DBEA_IDLE;
            cnt_q <= 16'h0000;
            scan_q <= 3'h0;
            pa_q <= 7'h00;
            pd_q <= 8'h00;
        end else begin
            case (st_q)
                DBEA_IDLE: begin
                    if (ena_q && !row_q && nvm_on && i_wr && tgt == DBEA_T_NVM) begin
                        st_q <= DBEA_BYTE; // [RL10] [RL13]
                        cnt_q <= 16'(PROG_CYCLES - 1); // [RL25]
                        pa_q <= {nvm_pg, i_addr[5:0]};
                        pd_q <= i_wdata;
                    end else if (row_go) begin
                        // Launch on the start write itself so busy lasts PROG_CYCLES
                        st_q <= DBEA_ROWP; // [RL16]
                        cnt_q <= 16'(PROG_CYCLES - 1);
                        scan_q <= 3'h0;
                    end
                end
                DBEA_BYTE: begin
                    if (cnt_q == 16'h0000) begin
                        st_q <= DBEA_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001; // [RL11]
                    end
                end
                DBEA_ROWP: begin
                    scan_q <= scan_q + 3'h1;
                    if (cnt_q == 16'h0000) begin
                        st_q <= DBEA_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: begin
                    st_q <= DBEA_IDLE;
                end
            endcase
        end
    end

    // Cell side outputs: one pulse per programmed byte
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_nvm_prog <= 1'b0;
            o_nvm_addr <= 7'h00;
            o_nvm_wdata <= 8'h00;
        end else if (st_q == DBEA_BYTE && cnt_q == 16'(PROG_CYCLES - 1)) begin
            o_nvm_prog <= 1'b1;
            o_nvm_addr <= pa_q;
            o_nvm_wdata <= pd_q;
        end else if (st_q == DBEA_ROWP && start_q && used_q[scan_q] && cnt_q > 16'(PROG_CYCLES - 9)) begin
            o_nvm_prog <= 1'b1; // [RL16]
            o_nvm_addr <= {row_pg_q, row_q_addr_q, scan_q};
            o_nvm_wdata <= lat_q[scan_q];
        end else begin
            o_nvm_prog <= 1'b0;
            o_nvm_addr <= {nvm_pg, i_addr[5:0]};
        end
    end

    // First read stage: array addresses go out, the read is remembered
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_q <= 1'b0;
            rd_ctl_q <= 1'b0;
            rd_nvm_ok_q <= 1'b0;
            rd_tgt_q <= DBEA_T_CORE;
        end else begin
            rd_q <= i_rd;
            rd_ctl_q <= i_rd && (i_addr == `DBEA_ADDR_NVM_CTL);
            rd_nvm_ok_q <= nvm_on && !busy; // [RL11] [RL12]
            rd_tgt_q <= tgt;
        end
    end

    // Core side reads, RAM page and window address
    // Arrays answer for the registered address, so data is taken one edge later
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
            o_rom_addr <= 12'h000;
            o_ram2_addr <= 6'h00;
            o_ram2_we <= 1'b0;
            o_ram2_wdata <= 8'h00;
            o_nvm_power <= 1'b0;
            o_nvm_busy <= 1'b0;
        end else begin
            o_rom_addr <= {win_q, i_addr[5:0]}; // [RL24]
            o_ram2_addr <= i_addr[5:0];
            o_ram2_we <= i_wr && tgt == DBEA_T_RAM2;
            o_ram2_wdata <= i_wdata;
            // Stop drops power on the very next edge unless a write is finishing
            o_nvm_power <= (nvm_on && !i_stop) || busy; // [RL21]
            o_nvm_busy <= busy;
            o_rvalid <= rd_q && (rd_tgt_q != DBEA_T_CORE || rd_ctl_q);
            if (rd_ctl_q) begin
                o_rdata <= {6'h00, busy, 1'b0}; // [RL11] [RL22]
            end else if (rd_q && rd_tgt_q == DBEA_T_WIN) begin
                o_rdata <= i_rom_rdata;
            end else if (rd_q && rd_tgt_q == DBEA_T_RAM2) begin
                o_rdata <= i_ram2_rdata;
            end else if (rd_q && rd_tgt_q == DBEA_T_NVM && rd_nvm_ok_q) begin
                o_rdata <= i_nvm_rdata; // [RL12]
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// ===== shared/dbea_defines.svh
// Constants of the data bank and nonvolatile access block.
// Assumes an 8-bit data space and a 12-bit program space.
`ifndef DBEA_DEFINES_SVH
`define DBEA_DEFINES_SVH
`define DBEA_ADDR_BANK_SEL 8'hE8
`define DBEA_ADDR_NVM_CTL 8'hEA
`define DBEA_ADDR_WIN_SEL 8'hC9
`define DBEA_PAGE_LAST 8'h3F
`define DBEA_WIN_FIRST 8'h40
`define DBEA_WIN_LAST 8'h7F
`define DBEA_BANK_RAM2 8'h10
`define DBEA_BANK_NVM0 8'h01
`define DBEA_BANK_NVM1 8'h02
`define DBEA_CTL_ENA 0
`define DBEA_CTL_BUSY 1
`define DBEA_CTL_ROW 2
`define DBEA_CTL_START 3
`define DBEA_CTL_OFF 6
`define DBEA_CTL_RESET 8'h00
`define DBEA_PROG_NS 10000
`define DBEA_CLK_MHZ 40
`define DBEA_PROG_CYC ((`DBEA_PROG_NS * `DBEA_CLK_MHZ) / 1000)
`endif

// ===== shared/dbea_pkg.sv
// Types of the data bank and nonvolatile access block.
// Assumes the defines header is compiled with it.
package dbea_pkg;
    // Programming sequencer states
    typedef enum logic [1:0] {
        DBEA_IDLE = 2'b00,
        DBEA_BYTE = 2'b01,
        DBEA_ROWP = 2'b10
    } dbea_state_t;
    // Data space routing target
    typedef enum logic [2:0] {
        DBEA_T_CORE = 3'b000,
        DBEA_T_RAM2 = 3'b001,
        DBEA_T_NVM = 3'b010,
        DBEA_T_WIN = 3'b011,
        DBEA_T_NONE = 3'b100
    } dbea_target_t;
endpackage

// ===== bench/dbea_data_bank_chk.sv
// Port checker for the data bank and nonvolatile access block.
// Assumes one clock domain and a bind onto dbea_data_bank.
`timescale 1ns/10ps
`default_nettype none
module dbea_data_bank_chk #(
    parameter int PROG_CYCLES = 16 // Programming length in clocks
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic i_stop,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic [11:0] o_rom_addr,
    input wire logic [5:0] o_ram2_addr,
    input wire logic o_ram2_we,
    input wire logic [7:0] o_ram2_wdata,
    input wire logic o_nvm_prog,
    input wire logic o_nvm_power,
    input wire logic o_nvm_busy
);
    int busy_cnt_q; // Busy cycles seen so far
    logic [4:0] wr_hist_q; // Recent write strobes
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Length of the current busy stretch
    always_ff @(posedge i_clk) begin
        busy_cnt_q <= (i_rst || !o_nvm_busy) ? 0 : busy_cnt_q + 1;
    end
    // Shift in write strobes so a busy start can be traced to its write
    always_ff @(posedge i_clk) begin
        wr_hist_q <= i_rst ? 5'h00 : {wr_hist_q[3:0], i_wr};
    end
    busy_len_a: assert property ($fell(o_nvm_busy) |-> busy_cnt_q == PROG_CYCLES)
        else $error("busy stretch length wrong");
    busy_cause_a: assert property ($rose(o_nvm_busy) |-> |wr_hist_q)
        else $error("busy without a write");
    prog_in_busy_a: assert property (o_nvm_prog |-> o_nvm_busy && o_nvm_power)
        else $error("program pulse outside busy");
    ctl_answer_a: assert property (i_rd && i_addr == 8'hEA |-> ##2 o_rvalid)
        else $error("control read unanswered");
    ctl_format_a: assert property (i_rd && i_addr == 8'hEA |-> ##2 o_rdata[7:2] == 6'h00 && !o_rdata[0])
        else $error("control read shows write-only bits");
    win_addr_a: assert property (i_rd && i_addr[7:6] == 2'b01 |=> o_rom_addr[5:0] == $past(i_addr[5:0]))
        else $error("window low address wrong");
    ram2_write_a: assert property (o_ram2_we |-> $past(i_wr) && o_ram2_addr == $past(i_addr[5:0])
        && o_ram2_wdata == $past(i_wdata))
        else $error("second page write mismatch");
    stop_off_a: assert property (i_stop && !o_nvm_busy |=> !o_nvm_power)
        else $error("stop left cells powered");
    reset_idle_a: assert property ($past(i_rst) |-> !o_nvm_busy && !o_rvalid)
        else $error("outputs active after reset");
endmodule
bind dbea_data_bank dbea_data_bank_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .i_stop(i_stop), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_rom_addr(o_rom_addr), .o_ram2_addr(o_ram2_addr), .o_ram2_we(o_ram2_we),
    .o_ram2_wdata(o_ram2_wdata), .o_nvm_prog(o_nvm_prog), .o_nvm_power(o_nvm_power), .o_nvm_busy(o_nvm_busy));
`default_nettype wire

// ===== bench/dbea_array_model.sv
// Model of the arrays behind the block: program memory, second RAM page, cells.
// Assumes combinational read data for the address currently presented.
`timescale 1ns/10ps
`default_nettype none
module dbea_array_model (
    input wire logic i_clk,
    input wire logic [11:0] i_rom_addr,
    input wire logic [5:0] i_ram2_addr,
    input wire logic i_ram2_we,
    input wire logic [7:0] i_ram2_wdata,
    input wire logic [6:0] i_nvm_addr,
    input wire logic [7:0] i_nvm_wdata,
    input wire logic i_nvm_prog,
    input wire logic i_nvm_power,
    output logic [7:0] o_ram2_rdata,
    output logic [7:0] o_rom_rdata,
    output logic [7:0] o_nvm_rdata
);
    logic [7:0] ram_q [64]; // Second RAM page
    logic [7:0] nvm_q [128]; // Cell array
    logic [7:0] flip_q = 8'hA5; // Garbage while unpowered
    // Store writes; each program pulse writes one byte
    always_ff @(posedge i_clk) begin
        flip_q <= ~flip_q;
        if (i_ram2_we) ram_q[i_ram2_addr] <= i_ram2_wdata;
        if (i_nvm_prog) nvm_q[i_nvm_addr] <= i_nvm_wdata;
    end
    assign o_rom_rdata = i_rom_addr[7:0] ^ {4'h0, i_rom_addr[11:8]};
    assign o_ram2_rdata = ram_q[i_ram2_addr];
    assign o_nvm_rdata = i_nvm_power ? nvm_q[i_nvm_addr] : flip_q;
endmodule
`default_nettype wire

// ===== bench/tb_dbea_data_bank.sv
// Self-checking bench for the data bank block.
// Assumes the array model and checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module tb_dbea_data_bank;
    localparam int PC = 16; // Short programming cycle
    logic i_clk, i_rst, i_wr, i_rd, i_stop, o_rvalid, o_ram2_we, o_nvm_prog, o_nvm_power, o_nvm_busy;
    logic [7:0] i_addr, i_wdata, o_rdata, o_ram2_wdata, o_nvm_wdata, ram2_rd, nvm_rd, rom_rd, last_d, pmask;
    logic [11:0] o_rom_addr;
    logic [5:0] o_ram2_addr;
    logic [6:0] o_nvm_addr, last_a;
    int err_total, compares, progs, r2n;
    // Window rows: window value, read address, expected program address
    logic [27:0] rows [4] = '{28'h28_59_A19, 28'hFF_40_FC0, 28'h00_7F_03F, 28'h3F_7F_FFF};
    dbea_data_bank #(.PROG_CYCLES(PC)) dbea_data_bank_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .i_stop(i_stop), .i_ram2_rdata(ram2_rd),
        .i_nvm_rdata(nvm_rd), .i_rom_rdata(rom_rd), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .o_rom_addr(o_rom_addr), .o_ram2_addr(o_ram2_addr), .o_ram2_we(o_ram2_we), .o_ram2_wdata(o_ram2_wdata),
        .o_nvm_addr(o_nvm_addr), .o_nvm_wdata(o_nvm_wdata), .o_nvm_prog(o_nvm_prog),
        .o_nvm_power(o_nvm_power), .o_nvm_busy(o_nvm_busy));
    dbea_array_model dbea_array_model_inst (.i_clk(i_clk), .i_rom_addr(o_rom_addr), .i_ram2_addr(o_ram2_addr),
        .i_ram2_we(o_ram2_we), .i_ram2_wdata(o_ram2_wdata), .i_nvm_addr(o_nvm_addr), .i_nvm_wdata(o_nvm_wdata),
        .i_nvm_prog(o_nvm_prog), .i_nvm_power(o_nvm_power), .o_ram2_rdata(ram2_rd), .o_rom_rdata(rom_rd),
        .o_nvm_rdata(nvm_rd));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // Record program pulses and page writes away from the clock edge
    always @(negedge i_clk) begin
        if (o_nvm_prog === 1'b1) begin
            progs++;
            last_a = o_nvm_addr;
            last_d = o_nvm_wdata;
            pmask[o_nvm_addr[2:0]] = 1'b1;
        end
        if (o_ram2_we === 1'b1) r2n++;
    end
    task automatic end_sim();
        $display("Compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // One core access; a read returns just after its data edge, two edges on
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        i_wr = w;
        i_rd = !w;
        i_addr = a;
        i_wdata = d;
        cyc(1);
        i_wr = 1'b0;
        i_rd = 1'b0;
        if (!w) cyc(1);
    endtask
    task automatic idle_wait();
        int n;
        n = 0;
        cyc(4);
        while (o_nvm_busy !== 1'b0 && n < 200) begin
            cyc(1);
            n++;
        end
        if (n == 200) begin
            err_total++;
            $display("Error at %0t: busy never cleared", $time);
            end_sim();
        end
    endtask
    initial begin
        {i_rst, i_wr, i_rd, i_stop, i_addr, i_wdata} = {4'h8, 16'h0000};
        {err_total, compares, progs, r2n, pmask} = '0;
        repeat (8) @(posedge i_clk);
        #1 i_rst = 1'b0;
        acc(0, 8'hEA, 8'h00);
        chk(12'(o_rdata), 12'h000);
        $display("Reset test done");
        foreach (rows[i]) begin
            acc(1, 8'hC9, rows[i][27:20]);
            acc(0, rows[i][19:12], 8'h00);
            chk(o_rom_addr, rows[i][11:0]);
            chk(12'(o_rvalid), 12'h001);
            chk(12'(o_rdata), 12'(rows[i][7:0] ^ {4'h0, rows[i][11:8]}));
        end
        $display("Window test done");
        acc(1, 8'hE8, 8'h10);
        acc(1, 8'h3F, 8'h5A);
        acc(1, 8'h40, 8'h11);
        cyc(1);
        chk(12'(r2n), 12'h001);
        acc(0, 8'h3F, 8'h00);
        chk(12'(o_rdata), 12'h05A);
        $display("Second page test done");
        acc(1, 8'hE8, 8'h01);
        acc(1, 8'hEA, 8'h01);
        cyc(1);
        chk(12'(o_nvm_power), 12'h001);
        acc(1, 8'h12, 8'hA5);
        cyc(4);
        acc(0, 8'hEA, 8'h00);
        chk(12'(o_rdata), 12'h002);
        acc(1, 8'hEA, 8'h40);
        idle_wait();
        chk(12'(progs), 12'h001);
        chk({5'h00, last_a}, 12'h012);
        chk(12'(last_d), 12'h0A5);
        acc(0, 8'h12, 8'h00);
        chk(12'(o_rdata), 12'h0A5);
        chk(12'(o_nvm_power), 12'h001);
        acc(1, 8'hEA, 8'h00);
        acc(1, 8'h13, 8'h3C);
        cyc(6);
        chk(12'(progs), 12'h001);
        $display("Byte write test done");
        {progs, pmask} = '0;
        acc(1, 8'hE8, 8'h02);
        acc(1, 8'hEA, 8'h05);
        acc(1, 8'h18, 8'h01);
        acc(1, 8'h1A, 8'h02);
        acc(1, 8'h1B, 8'h03);
        acc(1, 8'hEA, 8'h0D);
        idle_wait();
        chk(12'(progs), 12'h003);
        chk(12'(pmask), 12'h00D);
        chk(12'(last_a[6:3]), 12'h00B);
        acc(0, 8'h1A, 8'h00);
        chk(12'(o_rdata), 12'h002);
        acc(1, 8'hEA, 8'h0D);
        cyc(6);
        chk(12'(o_nvm_busy), 12'h000);
        acc(1, 8'hEA, 8'h05);
        acc(1, 8'h1C, 8'h77);
        acc(1, 8'hEA, 8'h01);
        acc(1, 8'hEA, 8'h09);
        cyc(6);
        chk(12'(progs), 12'h003);
        $display("Row test done");
        acc(1, 8'hEA, 8'h40);
        cyc(2);
        chk(12'(o_nvm_power), 12'h000);
        acc(1, 8'hEA, 8'h00);
        cyc(2);
        chk(12'(o_nvm_power), 12'h001);
        i_stop = 1'b1;
        cyc(1);
        i_stop = 1'b0;
        cyc(1);
        chk(12'(o_nvm_power), 12'h000);
        i_rst = 1'b1;
        cyc(2);
        i_rst = 1'b0;
        acc(0, 8'hEA, 8'h00);
        chk(12'(o_rdata), 12'h000);
        $display("Power and reset test done");
        end_sim();
    end
endmodule
`default_nettype wire
